// [rtl/msm_manager.sv]
// marriage manager: pairs a primary-elect and shadow-elect module over messages
// Function
// RULE1 - married modules run lock step, primary active, shadow passive
// RULE2 - pairing set only through register configuration, no fixed wiring
// RULE3 - both paired system buses may carry traffic normally
// RULE4 - partner_identity of each unit loaded with other's confinement_identifier
// RULE5 - married flag set in both pairs, shadow flag only in shadow
// RULE6 - silent-enable set in exactly one of the two pairs
// RULE7 - clearing sysbus_address_match disables the unit's address recognizer
// RULE8 - any error report restarts all deadlock timers
// RULE9 - arbitration_identity is write-only; same value written to both units
// RULE10 - clear lockstep_checker_pair toggle in both units before marriage
// RULE11 - invalidate-cache command clears caches; manager issues it
// RULE12 - access type 0100 is a physical register request; copies logical_identity
// RULE13 - copy all primary registers to shadow except six identity/control ones; code skips seven, indices 0 to 6
// RULE14 - shadow-elect: stop processors, set shadow flag, clear address match
// RULE15 - every step applied to all expansion units of a module
// RULE16 - shadow-elect gets unique module fault identity and source_identifier
// RULE17 - one synchronizing restart message after marriage
// RULE18 - logical 0010 register writes hit all units sharing that identity
// RULE19 - survivor clears married flag after partner permanent fault
// RULE20 - shadow tracks traffic but leaves responses to primary
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module msm_manager
  import msm_pkg::*;
#(
  parameter int NUM_UNITS = 1,
  parameter int REG_COUNT = 16
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interagent_message port
  output logic             msg_valid,
  output msm_msg_t         msg,
  input  wire logic        msg_ready,
  input  wire logic        rsp_valid,
  input  wire logic [31:0] rsp_data
);
  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  if (NUM_UNITS < 1 || NUM_UNITS > 16 || REG_COUNT <= int'(IDX_COPY0) || REG_COUNT > 256) begin : g_chk
    $error("msm_manager: unsupported NUM_UNITS or REG_COUNT");
  end

  localparam logic [3:0] LAST_UNIT = 4'(NUM_UNITS - 1);
  localparam logic [7:0] LAST_IDX  = 8'(REG_COUNT - 1);

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  logic [31:0]    prdata_r, prdata_nxt;
  logic           pready_r, pready_nxt;
  logic           pslverr_r, pslverr_nxt;
  logic           silsh_r, silsh_nxt;
  logic           tgl_r, tgl_nxt;
  logic [7:0]     ppid_r, ppid_nxt;
  logic [7:0]     spid_r, spid_nxt;
  logic [31:0]    smfi_r, smfi_nxt;
  logic [31:0]    ssrc_r, ssrc_nxt;
  logic [31:0]    arb_r, arb_nxt;
  logic           wr_acc;
  logic           start_req;
  logic           mapped;
  logic [31:0]    stat;
  // engine state
  msm_state_t     st_r, st_nxt;
  logic           side_r, side_nxt;
  logic [3:0]     unit_r, unit_nxt;
  logic [7:0]     idx_r, idx_nxt;
  logic           ph_r, ph_nxt;
  logic [31:0]    rdat_r, rdat_nxt;
  logic [31:0]    lid_r, lid_nxt;
  logic           mv_r, mv_nxt;
  msm_msg_t       msg_r, msg_nxt;
  logic           done_r, done_nxt;

  always_comb begin
    wr_acc    = psel && penable && pready_r && pwrite;
    start_req = wr_acc && paddr == A_CTRL && pwdata[CTL_START] && st_r == ST_IDLE;
    mapped    = paddr inside {A_CTRL, A_STAT, A_PPID, A_SPID, A_SMFI, A_SSRC, A_ARB, A_LID};
    stat      = '0;
    stat[STA_BUSY] = st_r != ST_IDLE;
    stat[STA_DONE] = done_r;
    stat[STA_ST_LSB +: 5] = st_r;
  end

  always_comb begin
    pready_nxt  = psel && !penable;
    pslverr_nxt = psel && !penable && !mapped;
    prdata_nxt  = prdata_r;
    silsh_nxt   = silsh_r;
    tgl_nxt     = tgl_r;
    ppid_nxt    = ppid_r;
    spid_nxt    = spid_r;
    smfi_nxt    = smfi_r;
    ssrc_nxt    = ssrc_r;
    arb_nxt     = arb_r;
    if (psel && !penable) begin
      prdata_nxt = '0;
      unique case (paddr)
        A_CTRL:  begin
          prdata_nxt[CTL_SILSH]  = silsh_r;
          prdata_nxt[CTL_TOGGLE] = tgl_r;
        end
        A_STAT:  prdata_nxt = stat;
        A_PPID:  prdata_nxt[7:0] = ppid_r;
        A_SPID:  prdata_nxt[7:0] = spid_r;
        A_SMFI:  prdata_nxt = smfi_r;
        A_SSRC:  prdata_nxt = ssrc_r;
        // write-only on the device too; never read back
        A_ARB:   prdata_nxt = '0;
        A_LID:   prdata_nxt = lid_r;
        default: prdata_nxt = '0;
      endcase
    end
    if (wr_acc) begin
      unique case (paddr)
        A_CTRL:  begin
          silsh_nxt = pwdata[CTL_SILSH];
          tgl_nxt   = pwdata[CTL_TOGGLE];
        end
        A_PPID:  ppid_nxt = pwdata[7:0];
        A_SPID:  spid_nxt = pwdata[7:0];
        A_SMFI:  smfi_nxt = pwdata;
        A_SSRC:  ssrc_nxt = pwdata;
        A_ARB:   arb_nxt  = pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      silsh_r   <= 1'b0;
      tgl_r     <= 1'b0;
      ppid_r    <= '0;
      spid_r    <= '0;
      smfi_r    <= '0;
      ssrc_r    <= '0;
      arb_r     <= '0;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      silsh_r   <= silsh_nxt;
      tgl_r     <= tgl_nxt;
      ppid_r    <= ppid_nxt;
      spid_r    <= spid_nxt;
      smfi_r    <= smfi_nxt;
      ssrc_r    <= ssrc_nxt;
      arb_r     <= arb_nxt;
    end
  end

  // ---------------------------------------------------------------
  // marriage sequence engine
  // ---------------------------------------------------------------
  function automatic logic st_both(msm_state_t s);
    return s inside {ST_CLR_TGL, ST_ARB, ST_MARRY, ST_SILENT};
  endfunction : st_both

  function automatic logic st_single(msm_state_t s);
    return s inside {ST_INVAL, ST_ERRRPT, ST_RESTART, ST_RD_MFIP, ST_RD_MFIS, ST_RD_LID};
  endfunction : st_single

  logic        cur_side;
  logic [7:0]  pid;
  logic        adv;
  msm_msg_t    m;

  always_comb begin
    st_nxt   = st_r;
    side_nxt = side_r;
    unit_nxt = unit_r;
    idx_nxt  = idx_r;
    ph_nxt   = ph_r;
    rdat_nxt = rdat_r;
    lid_nxt  = lid_r;
    mv_nxt   = mv_r;
    msg_nxt  = msg_r;
    done_nxt = done_r;
    adv      = 1'b0;
    cur_side = st_both(st_r) ? side_r :
               st_r inside {ST_STOP_SH, ST_SET_SHD, ST_CLRM_SH, ST_COPY_WR, ST_SET_MFI,
                            ST_SET_SRC, ST_WR_SPS, ST_RD_MFIS, ST_WR_LID};
    // RULE2 pairing by configured ids
    pid = (cur_side ? spid_r : ppid_r) + 8'(unit_r);
    m = '{kind: MK_WR, access: ACC_PHYS, target: pid, index: IDX_SPC, data: '0};
    unique case (st_r)
      // RULE14 stop shadow processors, then primary ones
      ST_STOP_SH, ST_STOP_PR: begin
        m.kind  = MK_CMD;
        m.index = CMD_STOP;
      end
      ST_SET_SHD: m.data[SPC_SHADOW] = 1'b1;
      // RULE7 recognizer off
      ST_CLRM_SH, ST_CLRM_PR: m.index = IDX_MATCH;
      // RULE10 toggle cleared in both
      ST_CLR_TGL: m.index = IDX_LCP;
      // RULE11 caches start equal
      ST_INVAL, ST_ERRRPT, ST_RESTART: begin
        m.kind   = MK_CMD;
        m.access = ACC_LOG;
        m.target = TGT_BCAST;
        m.index  = st_r == ST_INVAL ? CMD_INVAL :
                   st_r == ST_ERRRPT ? CMD_ERRRPT : CMD_RESTART;
      end
      // RULE13 copy excludes the identity block
      ST_COPY_RD: begin
        m.kind  = MK_RD;
        m.index = idx_r;
      end
      ST_COPY_WR: begin
        m.index = idx_r;
        m.data  = rdat_r;
      end
      // RULE9 same value to both
      ST_ARB: begin
        m.index = IDX_ARB;
        m.data  = arb_r;
      end
      // RULE16 unique identities
      ST_SET_MFI: begin
        m.index = IDX_MFI;
        m.data  = smfi_r;
      end
      ST_SET_SRC: begin
        m.index = IDX_BFI;
        m.data  = ssrc_r + 32'(unit_r);
      end
      ST_RD_MFIP, ST_RD_MFIS: begin
        m.kind  = MK_RD;
        m.index = IDX_MFI;
      end
      // RULE4 partner gets other confinement_identifier
      ST_WR_SPS, ST_WR_SPP: begin
        m.index = IDX_PARTNER;
        m.data  = rdat_r & CONF_MASK;
      end
      // RULE12 physical 0100 copy of logical_identity
      ST_RD_LID: begin
        m.kind  = MK_RD;
        m.index = IDX_LID;
      end
      ST_WR_LID: begin
        m.index = IDX_LID;
        m.data  = rdat_r;
      end
      // RULE5 married both, shadow only one
      ST_MARRY: begin
        m.data[SPC_MARRIED] = 1'b1;
        m.data[SPC_SHADOW]  = side_r;
        m.data[SPC_TOGGLE]  = tgl_r;
      end
      // RULE6 silent in one pair only
      ST_SILENT: begin
        m.index = IDX_FT2;
        // both pairs written: a silent bit copied from the primary must not survive
        m.data[FT2_SILENT] = side_r == silsh_r;
      end
      default: ;
    endcase
    if (st_r == ST_IDLE) begin
      if (start_req) begin
        st_nxt   = ST_STOP_SH;
        done_nxt = 1'b0;
        idx_nxt  = IDX_COPY0;
        side_nxt = 1'b0;
        unit_nxt = '0;
      end
    end else if (ph_r) begin
      if (rsp_valid) begin
        rdat_nxt = rsp_data;
        if (st_r == ST_RD_LID) lid_nxt = rsp_data;
        ph_nxt = 1'b0;
        adv    = 1'b1;
      end
    end else if (mv_r) begin
      if (msg_ready) begin
        mv_nxt = 1'b0;
        if (msg_r.kind == MK_RD) ph_nxt = 1'b1;
        else adv = 1'b1;
      end
    end else begin
      mv_nxt  = 1'b1;
      msg_nxt = m;
    end
    if (adv) begin
      if (st_r == ST_COPY_RD) begin
        st_nxt = ST_COPY_WR;
      end else if (st_r == ST_COPY_WR) begin
        if (unit_r != LAST_UNIT) begin
          unit_nxt = unit_r + 4'h1;
          st_nxt   = ST_COPY_RD;
        end else begin
          unit_nxt = '0;
          idx_nxt  = idx_r + 8'h01;
          st_nxt   = idx_r == LAST_IDX ? ST_ARB : ST_COPY_RD;
        end
      // RULE15 every expansion unit of a module
      end else if (!st_single(st_r) && unit_r != LAST_UNIT) begin
        unit_nxt = unit_r + 4'h1;
      end else if (st_both(st_r) && !side_r) begin
        side_nxt = 1'b1;
        unit_nxt = '0;
      end else begin
        side_nxt = 1'b0;
        unit_nxt = '0;
        // RULE17 restart ends the sequence
        if (st_r == ST_RESTART) begin
          st_nxt   = ST_IDLE;
          done_nxt = 1'b1;
        end else begin
          st_nxt = msm_state_t'(st_r + 5'h01);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r   <= ST_IDLE;
      side_r <= 1'b0;
      unit_r <= '0;
      idx_r  <= '0;
      ph_r   <= 1'b0;
      rdat_r <= '0;
      lid_r  <= '0;
      mv_r   <= 1'b0;
      msg_r  <= '0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      side_r <= side_nxt;
      unit_r <= unit_nxt;
      idx_r  <= idx_nxt;
      ph_r   <= ph_nxt;
      rdat_r <= rdat_nxt;
      lid_r  <= lid_nxt;
      mv_r   <= mv_nxt;
      msg_r  <= msg_nxt;
      done_r <= done_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign msg_valid = mv_r;
  assign msg       = msg_r;
endmodule : msm_manager

// [rtl/msm_pkg.sv]
// package: constants, message carrier and states of the marriage manager
package msm_pkg;
  // ---------------------------------------------------------------
  // interagent_message access types and commands
  // ---------------------------------------------------------------
  localparam logic [3:0] ACC_LOG  = 4'h2;
  localparam logic [3:0] ACC_PHYS = 4'h4;
  localparam logic [7:0] TGT_BCAST   = 8'hff;
  localparam logic [7:0] CMD_STOP    = 8'h01;
  localparam logic [7:0] CMD_RESTART = 8'h02;
  localparam logic [7:0] CMD_INVAL   = 8'h03;
  localparam logic [7:0] CMD_ERRRPT  = 8'h04;
  // ---------------------------------------------------------------
  // device register indices and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_SPC     = 8'h00; // shadow_pair_control
  localparam logic [7:0] IDX_PARTNER = 8'h01; // partner_identity
  localparam logic [7:0] IDX_MFI     = 8'h02; // module_fault_identity
  localparam logic [7:0] IDX_BFI     = 8'h03; // bus_fault_identity
  localparam logic [7:0] IDX_LID     = 8'h04; // logical_identity
  localparam logic [7:0] IDX_PID     = 8'h05; // physical_identity
  localparam logic [7:0] IDX_ARB     = 8'h06; // arbitration_identity
  localparam logic [7:0] IDX_MATCH   = 8'h07; // sysbus_address_match
  localparam logic [7:0] IDX_FT2     = 8'h08; // fault_tolerance_ctrl_two
  localparam logic [7:0] IDX_LCP     = 8'h09; // lockstep_checker_pair
  localparam logic [7:0] IDX_COPY0   = 8'h07; // first copied index
  localparam int SPC_MARRIED = 0;
  localparam int SPC_SHADOW  = 1;
  localparam int SPC_TOGGLE  = 2;
  localparam int FT2_SILENT  = 0;
  localparam logic [31:0] CONF_MASK = 32'h0000_00ff;
  // ---------------------------------------------------------------
  // apb register map
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_PPID = 8'h08;
  localparam logic [7:0] A_SPID = 8'h0c;
  localparam logic [7:0] A_SMFI = 8'h10;
  localparam logic [7:0] A_SSRC = 8'h14;
  localparam logic [7:0] A_ARB  = 8'h18;
  localparam logic [7:0] A_LID  = 8'h1c;
  localparam int CTL_START   = 0;
  localparam int CTL_SILSH   = 1;
  localparam int CTL_TOGGLE  = 2;
  localparam int STA_BUSY    = 0;
  localparam int STA_DONE    = 1;
  localparam int STA_ST_LSB  = 8;
  // ---------------------------------------------------------------
  // carrier and states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {MK_WR = 2'b00, MK_RD = 2'b01, MK_CMD = 2'b10} msm_kind_t;
  typedef struct packed {
    msm_kind_t   kind;
    logic [3:0]  access;
    logic [7:0]  target;
    logic [7:0]  index;
    logic [31:0] data;
  } msm_msg_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00000, ST_STOP_SH = 5'b00001, ST_SET_SHD = 5'b00010,
    ST_CLRM_SH = 5'b00011, ST_STOP_PR = 5'b00100, ST_CLRM_PR = 5'b00101,
    ST_CLR_TGL = 5'b00110, ST_INVAL = 5'b00111, ST_ERRRPT = 5'b01000,
    ST_COPY_RD = 5'b01001, ST_COPY_WR = 5'b01010, ST_ARB = 5'b01011,
    ST_SET_MFI = 5'b01100, ST_SET_SRC = 5'b01101, ST_RD_MFIP = 5'b01110,
    ST_WR_SPS = 5'b01111, ST_RD_MFIS = 5'b10000, ST_WR_SPP = 5'b10001,
    ST_RD_LID = 5'b10010, ST_WR_LID = 5'b10011, ST_MARRY = 5'b10100,
    ST_SILENT = 5'b10101, ST_RESTART = 5'b10110
  } msm_state_t;
endpackage : msm_pkg

// [testbench/msm_dev_model.sv]
// far-side model: expansion units of both modules behind the message port
`timescale 1ns/100ps
module msm_dev_model
  import msm_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // stall control
  input  wire logic        slow,
  // message port
  input  wire logic        msg_valid,
  input  wire msm_msg_t    msg,
  output logic             msg_ready,
  output logic             rsp_valid,
  output logic [31:0]      rsp_data
);
  // one port serves both paired buses; no message waits on a bus choice
  // each unit keyed by physical_identity; match word zero means deaf
  logic [31:0] regs [4096];
  int          cmd_cnt [256];
  int          wc;
  int          rc;
  logic        go;
  logic [31:0] rd_val;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      msg_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 32'h0;
      wc = 0;
      rc = 0;
    end else begin
      go = 1'b0;
      msg_ready <= msg_valid && !msg_ready && wc >= (slow ? 3 : 0);
      wc = (msg_valid && !msg_ready) ? wc + 1 : 0;
      if (msg_valid && msg_ready) begin
        case (msg.kind)
          // physical hits one unit, logical every unit of that identity
          MK_WR: begin
            if (msg.access == ACC_PHYS) regs[{msg.target, msg.index[3:0]}] <= msg.data;
            else for (int t = 0; t < 256; t++)
              if (regs[{8'(t), 4'h4}][7:0] == msg.target) regs[{8'(t), msg.index[3:0]}] <= msg.data;
          end
          // write-only identity reads back as zero
          MK_RD: begin
            rd_val = (msg.index == IDX_ARB) ? 32'h0 : regs[{msg.target, msg.index[3:0]}];
            rc = slow ? 5 : 1;
          end
          // timers, caches, stop and restart counted
          default: cmd_cnt[msg.index] = cmd_cnt[msg.index] + 1;
        endcase
      end else if (rc > 0) begin
        rc = rc - 1;
        go = (rc == 0);
      end
      rsp_valid <= go;
      // released data line toggles so a stale sample never matches
      rsp_data  <= go ? rd_val : ~rsp_data;
    end
  end
  // married shadow stays passive; primary or unmarried unit answers
  function automatic logic answers(input logic [7:0] t);
    return regs[{t, 4'(IDX_MATCH)}] != 32'h0 &&
           !(regs[{t, 4'(IDX_SPC)}][SPC_MARRIED] && regs[{t, 4'(IDX_SPC)}][SPC_SHADOW]);
  endfunction : answers
endmodule : msm_dev_model

// [testbench/msm_manager_properties.sv]
// checker: port-level properties of the marriage manager
`timescale 1ns/100ps
module msm_manager_checker
  import msm_pkg::*;
#(
  parameter int NUM_UNITS = 1,
  parameter int REG_COUNT = 16
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // message port
  input wire logic        msg_valid,
  input wire msm_msg_t    msg,
  input wire logic        msg_ready,
  input wire logic        rsp_valid,
  input wire logic [31:0] rsp_data
);
  logic [7:0] spid_r;
  logic       is_sh;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // snooped so the shadow range is known without a wire to the engine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) spid_r <= 8'h00;
    else if (psel && penable && pwrite && paddr == A_SPID) spid_r <= pwdata[7:0];
  end
  assign is_sh = (msg.target >= spid_r) && (msg.target < spid_r + NUM_UNITS);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  AST_APB_ZERO_WAIT: assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
  AST_APB_IDLE: assert property (!(psel && penable) |-> !pready && !pslverr)
    else $error("ready outside access cycle");
  AST_APB_UNMAPPED: assert property (psel && penable && paddr > A_LID |-> pslverr)
    else $error("unmapped address not refused");
  AST_MSG_HOLD: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg))
    else $error("message changed before it was taken");
  AST_MSG_GAP: assert property (msg_valid && msg_ready |=> !msg_valid)
    else $error("message not dropped after handshake");
  AST_REG_PHYS: assert property (msg_valid && msg.kind != MK_CMD |-> msg.access == ACC_PHYS)
    else $error("register request not physical");
  AST_CMD_BCAST: assert property (msg_valid && msg.kind == MK_CMD && msg.index != CMD_STOP
    |-> msg.access == ACC_LOG && msg.target == TGT_BCAST)
    else $error("broadcast command malformed");
  AST_NO_ARB_READ: assert property (msg_valid && msg.kind == MK_RD
    |-> msg.index != IDX_ARB && msg.index < REG_COUNT)
    else $error("read of write-only or absent register");
  AST_PARTNER_MASK: assert property (msg_valid && msg.kind == MK_WR && msg.index == IDX_PARTNER
    |-> (msg.data & ~CONF_MASK) == 32'h0)
    else $error("partner value wider than confinement field");
  AST_SHADOW_ONLY: assert property (msg_valid && msg.kind == MK_WR && msg.index == IDX_SPC
    |-> msg.data[SPC_SHADOW] == is_sh)
    else $error("shadow flag on wrong side");
  AST_PREP_SHADOW: assert property (msg_valid && msg.kind == MK_WR && msg.index == IDX_SPC
    && !msg.data[SPC_MARRIED] |-> is_sh && msg.data[SPC_SHADOW])
    else $error("unmarried pair control write off the shadow");
  AST_LCP_CLEAR: assert property (msg_valid && msg.kind == MK_WR && msg.index == IDX_LCP
    |-> msg.data == 32'h0)
    else $error("checker pair toggle not cleared");
endmodule : msm_manager_checker

bind msm_manager msm_manager_checker #(.NUM_UNITS(NUM_UNITS), .REG_COUNT(REG_COUNT))
  msm_manager_checker_inst (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .msg_valid(msg_valid), .msg(msg), .msg_ready(msg_ready),
  .rsp_valid(rsp_valid), .rsp_data(rsp_data));

// [testbench/tb_top.sv]
// testbench: runs the marriage sequence twice against the far-side model
`timescale 1ns/100ps
module tb_top
  import msm_pkg::*;
;
  localparam int         NU = 2;
  localparam logic [7:0] PP = 8'h10;
  localparam logic [7:0] SP = 8'h20;
  logic        clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        msg_valid;
  msm_msg_t    msg;
  logic        msg_ready;
  logic        rsp_valid;
  logic [31:0] rsp_data;
  logic        slow;
  int          miscompares;
  int          compares;
  msm_manager #(.NUM_UNITS(NU), .REG_COUNT(16)) msm_manager_inst (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid), .msg(msg),
    .msg_ready(msg_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  msm_dev_model msm_dev_model_inst (.clk(clk), .reset_n(reset_n), .slow(slow),
    .msg_valid(msg_valid), .msg(msg), .msg_ready(msg_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      miscompares++;
      stop_test();
    end
  endtask : apb
  function automatic logic [31:0] pv(input int run, input int u, input int i);
    return 32'h5a00_0000 + 32'(run * 256 + u * 16 + i);
  endfunction : pv
  function automatic logic [31:0] rg(input logic [7:0] b, input int u, input int i);
    return msm_dev_model_inst.regs[{b + 8'(u), 4'(i)}];
  endfunction : rg
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic        e;
    logic [31:0] sm;
    logic [31:0] tg;
    int          n;
    {reset_n, psel, penable, pwrite, paddr, pwdata, slow} = '0;
    miscompares = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    apb(0, A_STAT, 32'h0, r, e);
    chk(r, 32'h0);
    apb(0, 8'h40, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    for (int run = 0; run < 2; run++) begin
      slow <= run[0];
      sm = 32'h0000_00c4 + 32'(run);
      tg = 32'(run) << SPC_TOGGLE;
      for (int u = 0; u < NU; u++) begin
        for (int i = 0; i < 16; i++) begin
          msm_dev_model_inst.regs[{PP + 8'(u), 4'(i)}] = pv(run, u, i);
          msm_dev_model_inst.regs[{SP + 8'(u), 4'(i)}] = 32'hc3c3_0000;
        end
        // silent bit preset on the primary, so a copied flag shows up
        msm_dev_model_inst.regs[{PP + 8'(u), 4'(IDX_FT2)}] = 32'h1;
      end
      for (int c = 1; c < 5; c++) msm_dev_model_inst.cmd_cnt[c] = 0;
      apb(1, A_PPID, {24'h0, PP}, r, e);
      apb(1, A_SPID, {24'h0, SP}, r, e);
      apb(1, A_SMFI, sm, r, e);
      apb(1, A_SSRC, 32'h0000_0050, r, e);
      apb(1, A_ARB, sm + 32'h10, r, e);
      apb(0, A_ARB, 32'h0, r, e);
      chk(r, 32'h0);
      apb(1, A_CTRL, run ? 32'h7 : 32'h1, r, e);
      apb(0, A_STAT, 32'h0, r, e);
      chk(r & 32'h1, 32'h1);
      // start while busy must not launch a second sequence
      apb(1, A_CTRL, run ? 32'h7 : 32'h1, r, e);
      n = 0;
      do begin
        apb(0, A_STAT, 32'h0, r, e);
        n++;
      end while (r[STA_DONE] !== 1'b1 && n < 2000);
      if (n >= 2000) begin
        miscompares++;
        stop_test();
      end
      chk(r & 32'h3, 32'h2);
      apb(0, A_LID, 32'h0, r, e);
      chk(r, pv(run, 0, 4));
      chk(32'(msm_dev_model_inst.cmd_cnt[CMD_STOP]), 32'(2 * NU));
      chk(32'(msm_dev_model_inst.cmd_cnt[CMD_INVAL]), 32'h1);
      chk(32'(msm_dev_model_inst.cmd_cnt[CMD_ERRRPT]), 32'h1);
      chk(32'(msm_dev_model_inst.cmd_cnt[CMD_RESTART]), 32'h1);
      for (int u = 0; u < NU; u++) begin
        for (int i = 10; i < 16; i++) chk(rg(SP, u, i), pv(run, u, i));
        chk(rg(SP, u, IDX_MATCH) | rg(PP, u, IDX_MATCH), 32'h0);
        chk(rg(SP, u, IDX_LCP) | rg(PP, u, IDX_LCP), 32'h0);
        chk(rg(SP, u, IDX_ARB) ^ rg(PP, u, IDX_ARB), 32'h0);
        chk(rg(PP, u, IDX_ARB), sm + 32'h10);
        chk(rg(SP, u, IDX_MFI), sm);
        chk(rg(SP, u, IDX_BFI), 32'h0000_0050 + 32'(u));
        chk(rg(SP, u, IDX_PARTNER), pv(run, 0, 2) & CONF_MASK);
        chk(rg(PP, u, IDX_PARTNER), sm & CONF_MASK);
        chk(rg(SP, u, IDX_LID), pv(run, 0, 4));
        chk(rg(PP, u, IDX_SPC), (32'h1 << SPC_MARRIED) | tg);
        chk(rg(SP, u, IDX_SPC), (32'h1 << SPC_MARRIED) | (32'h1 << SPC_SHADOW) | tg);
        chk(rg(PP, u, IDX_FT2) & 32'h1, 32'(run == 0));
        chk(rg(SP, u, IDX_FT2) & 32'h1, 32'(run));
        // recognizers enabled afterwards, as a later setup step would
        msm_dev_model_inst.regs[{PP + 8'(u), 4'(IDX_MATCH)}] = 32'h1;
        msm_dev_model_inst.regs[{SP + 8'(u), 4'(IDX_MATCH)}] = 32'h1;
        chk(32'(msm_dev_model_inst.answers(PP + 8'(u))), 32'h1);
        chk(32'(msm_dev_model_inst.answers(SP + 8'(u))), 32'h0);
        msm_dev_model_inst.regs[{SP + 8'(u), 4'(IDX_SPC)}][SPC_MARRIED] = 1'b0;
        chk(32'(msm_dev_model_inst.answers(SP + 8'(u))), 32'h1);
      end
    end
    stop_test();
  end
endmodule : tb_top
